/* File: hw/atfr_regs.sv */
// Oscillator trim, backend fault restart, input routing and PWM crossbar
// What this block and its host must do
// [R01] Internal oscillator detects audio clock rate
// [R02] Host recalibrates oscillator after every reset
// [R03] Writing zero to trim applies factory trim
// [R04] Trim register reads zero when trimming finished
// [R05] Trim D6 read-only done flag, resets 0
// [R06] Trim D1 zero selects factory, resets 1
// [R07] Backend error resets stage, halts PWM immediately
// [R08] Wait programmed period, then restart power stage
// [R09] Low nibble codes select 299..1496 ms wait
// [R10] Fault register: valid values, one write only
// [R11] D26..D24 invert channels three, two, one
// [R12] D23 picks channel one modulation scheme
// [R13] Channel one source: left, right or zero
// [R14] D19 picks channel two modulation scheme
// [R15] Channel two source: left, right or zero
// [R16] D3 picks subwoofer modulation in 2.1
// [R17] Fourth channel: average or equalized left
// [R18] Crossbar maps any PWM channel to pin
// [R19] Selector code equals channel number minus one
// [R20] Reset map: A=ch1, B=ch3, C=ch2
// [R21] Host reprograms delays for three-level use
// [R22] Host keeps reserved bits at reset values
`timescale 1ns/1ps
`default_nettype none
module atfr_regs #(
	parameter int unsigned CYC_MS = atfr_pkg::CYC_PER_MS
) (
	input  wire logic                          core_clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          ce_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	input  wire logic [7:0]                    reg_addr_i,
	input  wire logic [31:0]                   reg_wdata_i,
	output logic      [31:0]                   reg_rdata_o,
	output logic                               reg_rvalid_o,
	output logic                               trim_factory_o,
	output logic                               trim_done_o,
	input  wire logic                          backend_fault_register_i,
	output logic                               pwr_stage_rst_o,
	input  wire logic [atfr_pkg::CH_N-1:0]     pwm_ch_i,
	output logic      [atfr_pkg::CH_N-1:0]     pwm_pin_o,
	output logic      [2:0]                    mod_three_level_o,
	input  wire logic                          in_valid_i,
	output logic                               in_ready_o,
	input  wire logic [atfr_pkg::SAMPLE_W-1:0] serial_input_left_i,
	input  wire logic [atfr_pkg::SAMPLE_W-1:0] serial_input_right_i,
	input  wire logic [atfr_pkg::SAMPLE_W-1:0] after_equalizer_biquads_i,
	output logic                               ch_valid_o,
	input  wire logic                          ch_ready_i,
	output logic [atfr_pkg::CH_N*atfr_pkg::SAMPLE_W-1:0] ch_data_o
);
	import atfr_pkg::*;

	typedef logic [SAMPLE_W-1:0] atfr_smp_t;

	logic [31:0]    trim_reg, bknd_reg, inmux_reg, ch4_reg, xbar_reg;
	logic           trim_busy_reg, trim_done_reg, bk_locked_reg;
	logic [3:0]     trim_cnt_reg;
	logic [31:0]    fault_cnt_reg;
	atfr_fault_st_t fault_st_reg, fault_st_next;
	logic [31:0]    rdata_next;

	function automatic atfr_smp_t atfr_src(input logic [2:0] code, input atfr_smp_t l, input atfr_smp_t r);
		case (code)
			SRC_LEFT:  atfr_src = l;
			SRC_RIGHT: atfr_src = r;
			default:   atfr_src = '0;
		endcase
	endfunction : atfr_src

	function automatic atfr_smp_t atfr_pol(input logic inv, input atfr_smp_t x);
		atfr_pol = inv ? atfr_smp_t'(-x) : x;
	endfunction : atfr_pol

	function automatic logic [31:0] atfr_wmask(input logic [31:0] w, input logic [31:0] m, input logic [31:0] r);
		atfr_wmask = (w & m) | (r & ~m);
	endfunction : atfr_wmask

	// Address decode
	wire wr_trim  = ce_i && reg_wr_i && (reg_addr_i == ADDR_TRIM);
	wire wr_bknd  = ce_i && reg_wr_i && (reg_addr_i == ADDR_BKND);
	wire wr_inmux = ce_i && reg_wr_i && (reg_addr_i == ADDR_INMUX);
	wire wr_ch4   = ce_i && reg_wr_i && (reg_addr_i == ADDR_CH4);
	wire wr_xbar  = ce_i && reg_wr_i && (reg_addr_i == ADDR_XBAR);
	wire trim_start = wr_trim && (reg_wdata_i == 32'h0);
	wire bk_accept  = wr_bknd && !bk_locked_reg && atfr_bknd_ok(reg_wdata_i);

	// Oscillator trim: zero write starts the factory trim sequence
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			trim_reg      <= RST_TRIM;
			trim_busy_reg <= 1'b0;
			trim_done_reg <= 1'b0;
			trim_cnt_reg  <= '0;
		end else if (ce_i) begin
			if (trim_start) begin
				trim_reg      <= 32'h0; // [R03] [R06]
				trim_busy_reg <= 1'b1;
				trim_done_reg <= 1'b0;
				trim_cnt_reg  <= TRIM_CYCLES;
			end else if (trim_busy_reg) begin
				trim_cnt_reg <= trim_cnt_reg - 4'h1;
				if (trim_cnt_reg == 4'h0) begin
					trim_busy_reg <= 1'b0;
					trim_done_reg <= 1'b1; // [R05] [R01]
				end
			end else if (wr_trim) begin
				trim_reg[TRIM_SEL_BIT] <= reg_wdata_i[TRIM_SEL_BIT]; // [R06]
			end
		end
	end

	// Done is hidden while factory trim is selected so a finished zero write reads zero
	wire [31:0] trim_rd = {25'h0, trim_done_reg & trim_reg[TRIM_SEL_BIT] & !trim_busy_reg, 4'h0,
		trim_reg[TRIM_SEL_BIT] | trim_busy_reg, 1'b0}; // [R04] [R05]

	// Routing registers; reserved bits always hold their reset pattern
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			bknd_reg      <= RST_BKND;
			bk_locked_reg <= 1'b0;
			inmux_reg     <= RST_INMUX;
			ch4_reg       <= RST_CH4;
			xbar_reg      <= RST_XBAR; // [R20]
		end else if (ce_i) begin
			if (bk_accept) begin
				bknd_reg      <= reg_wdata_i; // [R10]
				bk_locked_reg <= 1'b1;        // [R10]
			end
			if (wr_inmux) begin
				inmux_reg <= atfr_wmask(reg_wdata_i, MSK_INMUX, RST_INMUX);
			end
			if (wr_ch4) begin
				ch4_reg <= atfr_wmask(reg_wdata_i, MSK_CH4, RST_CH4);
			end
			if (wr_xbar) begin
				xbar_reg <= atfr_wmask(reg_wdata_i, MSK_XBAR, RST_XBAR);
			end
		end
	end

	assign rdata_next = (reg_addr_i == ADDR_TRIM)  ? trim_rd :
	                    (reg_addr_i == ADDR_BKND)  ? bknd_reg :
	                    (reg_addr_i == ADDR_INMUX) ? inmux_reg :
	                    (reg_addr_i == ADDR_CH4)   ? ch4_reg :
	                    (reg_addr_i == ADDR_XBAR)  ? xbar_reg : 32'h0;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_o  <= '0;
			reg_rvalid_o <= 1'b0;
		end else if (ce_i) begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rdata_next;
			end
		end
	end

	// Backend fault recovery
	wire [31:0] delay_cyc = 32'(atfr_delay_ms(bknd_reg[3:0]) * CYC_MS); // [R09]

	always_comb begin
		fault_st_next = fault_st_reg;
		case (fault_st_reg)
			ATFR_RUN:     if (backend_fault_register_i) fault_st_next = ATFR_HALT; // [R07]
			ATFR_HALT:    if (fault_cnt_reg == 32'h0) fault_st_next = ATFR_RESTART; // [R08]
			ATFR_RESTART: fault_st_next = ATFR_RUN;
			default:      fault_st_next = ATFR_RUN;
		endcase
	end

	wire halt_next = (fault_st_next == ATFR_HALT);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			fault_st_reg    <= ATFR_RUN;
			fault_cnt_reg   <= '0;
			pwr_stage_rst_o <= 1'b0;
		end else if (ce_i) begin
			fault_st_reg    <= fault_st_next;
			pwr_stage_rst_o <= halt_next; // [R07]
			if (fault_st_reg == ATFR_RUN) begin
				fault_cnt_reg <= delay_cyc - 32'h1; // [R08] [R09]
			end else if (fault_cnt_reg != 32'h0) begin
				fault_cnt_reg <= fault_cnt_reg - 32'h1;
			end
		end
	end

	// Crossbar; pins drop low in the same edge the stage is reset
	wire [1:0] sel_a = xbar_reg[XBAR_A_LSB +: 2];
	wire [1:0] sel_b = xbar_reg[XBAR_B_LSB +: 2];
	wire [1:0] sel_c = xbar_reg[XBAR_C_LSB +: 2];
	wire [1:0] sel_d = xbar_reg[XBAR_D_LSB +: 2];
	wire [CH_N-1:0] pin_next = halt_next ? '0 :
		{pwm_ch_i[sel_d], pwm_ch_i[sel_c], pwm_ch_i[sel_b], pwm_ch_i[sel_a]}; // [R18] [R19] [R07]

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pwm_pin_o         <= '0;
			trim_factory_o    <= 1'b0;
			trim_done_o       <= 1'b0;
			mod_three_level_o <= '0;
		end else if (ce_i) begin
			pwm_pin_o         <= pin_next;
			trim_factory_o    <= !trim_reg[TRIM_SEL_BIT]; // [R06]
			trim_done_o       <= trim_done_reg;
			mod_three_level_o <= {inmux_reg[MOD_SUB_BIT], inmux_reg[MOD_CH2_BIT], inmux_reg[MOD_CH1_BIT]}; // [R12] [R14] [R16]
		end
	end

	// Input routing; channel 3 follows the channel 1 source
	wire [2:0] src1 = inmux_reg[SRC_CH1_LSB +: 3];
	wire [2:0] src2 = inmux_reg[SRC_CH2_LSB +: 3];
	wire atfr_smp_t raw1 = atfr_src(src1, serial_input_left_i, serial_input_right_i); // [R13]
	wire atfr_smp_t raw2 = atfr_src(src2, serial_input_left_i, serial_input_right_i); // [R15]
	wire atfr_smp_t ch1 = atfr_pol(inmux_reg[INV_CH1_BIT], raw1);     // [R11]
	wire atfr_smp_t ch2 = atfr_pol(inmux_reg[INV_CH1_BIT + 1], raw2); // [R11]
	wire atfr_smp_t ch3 = atfr_pol(inmux_reg[INV_CH1_BIT + 2], raw1); // [R11]
	wire [SAMPLE_W:0] lr_sum = {serial_input_left_i[SAMPLE_W-1], serial_input_left_i}
		+ {serial_input_right_i[SAMPLE_W-1], serial_input_right_i};
	wire atfr_smp_t ch4 = ch4_reg[CH4_SEL_BIT] ? after_equalizer_biquads_i : lr_sum[SAMPLE_W:1]; // [R17]

	// Skid buffer holds a word while the receiver stalls
	atfr_skid #(.W(CH_N * SAMPLE_W)) u_skid (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.s_valid_i  (in_valid_i),
		.s_ready_o  (in_ready_o),
		.s_data_i   ({ch4, ch3, ch2, ch1}),
		.m_valid_o  (ch_valid_o),
		.m_ready_i  (ch_ready_i),
		.m_data_o   (ch_data_o)
	);

	// Checks
	property p_fault_halt;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && fault_st_reg == ATFR_RUN && backend_fault_register_i |=> pwr_stage_rst_o && pwm_pin_o == '0;
	endproperty
	a_fault_halt: assert property (p_fault_halt) else $error("fault did not halt pwm"); // [R07]

	property p_fault_load;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && fault_st_reg == ATFR_RUN && backend_fault_register_i |=> fault_cnt_reg == $past(delay_cyc) - 32'h1;
	endproperty
	a_fault_load: assert property (p_fault_load) else $error("restart wait wrong"); // [R09]

	property p_restart;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && fault_st_reg == ATFR_HALT && fault_cnt_reg == 32'h0 |=> fault_st_reg == ATFR_RESTART
			##1 !pwr_stage_rst_o || !ce_i;
	endproperty
	a_restart: assert property (p_restart) else $error("stage not restarted"); // [R08]

	property p_trim_done;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && trim_busy_reg && trim_cnt_reg == 4'h0 && !wr_trim |=> trim_done_reg && !trim_busy_reg;
	endproperty
	a_trim_done: assert property (p_trim_done) else $error("trim never finished"); // [R05]

	property p_trim_zero;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && reg_rd_i && reg_addr_i == ADDR_TRIM && trim_done_reg && !trim_reg[TRIM_SEL_BIT]
			|=> reg_rdata_o == 32'h0 && reg_rvalid_o;
	endproperty
	a_trim_zero: assert property (p_trim_zero) else $error("trim readback not zero"); // [R04]

	property p_bknd_once;
		@(posedge core_clk_i) disable iff (rst_i)
		bk_locked_reg && wr_bknd |=> $stable(bknd_reg);
	endproperty
	a_bknd_once: assert property (p_bknd_once) else $error("fault register rewritten"); // [R10]

	property p_xbar_a;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && !halt_next |=> pwm_pin_o[0] == $past(pwm_ch_i[sel_a]);
	endproperty
	a_xbar_a: assert property (p_xbar_a) else $error("pin a mapping wrong"); // [R18]

	property p_src_gnd;
		@(posedge core_clk_i) disable iff (rst_i)
		src1 == SRC_GND |-> ch1 == '0 && ch3 == '0;
	endproperty
	a_src_gnd: assert property (p_src_gnd) else $error("grounded source not zero"); // [R13]

	property p_ch4_avg;
		@(posedge core_clk_i) disable iff (rst_i)
		!ch4_reg[CH4_SEL_BIT] && serial_input_left_i == serial_input_right_i |-> ch4 == serial_input_left_i;
	endproperty
	a_ch4_avg: assert property (p_ch4_avg) else $error("average source wrong"); // [R17]

	c_fault: cover property (@(posedge core_clk_i) disable iff (rst_i) fault_st_reg == ATFR_HALT);
	c_restart: cover property (@(posedge core_clk_i) disable iff (rst_i) fault_st_reg == ATFR_RESTART);
	c_trim: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(trim_done_reg));
endmodule : atfr_regs
`default_nettype wire

/* File: shared/atfr_pkg.sv */
// Constants, register map and helper functions for the trim, fault and routing block
package atfr_pkg;
	localparam int unsigned SAMPLE_W      = 24;
	localparam int unsigned CH_N          = 4;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_IN_NS      = 1000000;
	localparam int unsigned CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  TRIM_CYCLES   = 4'hf;

	localparam logic [7:0]  ADDR_TRIM  = 8'h1b;
	localparam logic [7:0]  ADDR_BKND  = 8'h1c;
	localparam logic [7:0]  ADDR_INMUX = 8'h20;
	localparam logic [7:0]  ADDR_CH4   = 8'h21;
	localparam logic [7:0]  ADDR_XBAR  = 8'h25;

	localparam logic [31:0] RST_TRIM  = 32'h0000_0002;
	localparam logic [31:0] RST_BKND  = 32'h0000_0002;
	localparam logic [31:0] RST_INMUX = 32'h0001_7772;
	localparam logic [31:0] RST_CH4   = 32'h0000_4303;
	localparam logic [31:0] RST_XBAR  = 32'h0102_1300;
	localparam logic [31:0] MSK_INMUX = 32'h07ff_0008;
	localparam logic [31:0] MSK_CH4   = 32'h0000_0100;
	localparam logic [31:0] MSK_XBAR  = 32'h0033_3300;

	localparam int unsigned TRIM_DONE_BIT = 6;
	localparam int unsigned TRIM_SEL_BIT  = 1;
	localparam int unsigned INV_CH1_BIT   = 24;
	localparam int unsigned MOD_CH1_BIT   = 23;
	localparam int unsigned SRC_CH1_LSB   = 20;
	localparam int unsigned MOD_CH2_BIT   = 19;
	localparam int unsigned SRC_CH2_LSB   = 16;
	localparam int unsigned MOD_SUB_BIT   = 3;
	localparam int unsigned CH4_SEL_BIT   = 8;
	localparam int unsigned XBAR_A_LSB    = 20;
	localparam int unsigned XBAR_B_LSB    = 16;
	localparam int unsigned XBAR_C_LSB    = 12;
	localparam int unsigned XBAR_D_LSB    = 8;

	localparam logic [2:0]  SRC_LEFT  = 3'h0;
	localparam logic [2:0]  SRC_RIGHT = 3'h1;
	localparam logic [2:0]  SRC_GND   = 3'h6;

	// Restart wait in ms: 299,449,598,748,898,1047,1197,1346,1496
	localparam logic [10:0] BK_MS_2  = 11'h12b;
	localparam logic [10:0] BK_MS_3  = 11'h1c1;
	localparam logic [10:0] BK_MS_4  = 11'h256;
	localparam logic [10:0] BK_MS_5  = 11'h2ec;
	localparam logic [10:0] BK_MS_6  = 11'h382;
	localparam logic [10:0] BK_MS_7  = 11'h417;
	localparam logic [10:0] BK_MS_8  = 11'h4ad;
	localparam logic [10:0] BK_MS_9  = 11'h542;
	localparam logic [10:0] BK_MS_HI = 11'h5d8;

	typedef enum logic [2:0] {
		ATFR_RUN     = 3'b001,
		ATFR_HALT    = 3'b010,
		ATFR_RESTART = 3'b100
	} atfr_fault_st_t;

	function automatic logic [10:0] atfr_delay_ms(input logic [3:0] code);
		case (code)
			4'h2:    atfr_delay_ms = BK_MS_2;
			4'h3:    atfr_delay_ms = BK_MS_3;
			4'h4:    atfr_delay_ms = BK_MS_4;
			4'h5:    atfr_delay_ms = BK_MS_5;
			4'h6:    atfr_delay_ms = BK_MS_6;
			4'h7:    atfr_delay_ms = BK_MS_7;
			4'h8:    atfr_delay_ms = BK_MS_8;
			4'h9:    atfr_delay_ms = BK_MS_9;
			default: atfr_delay_ms = BK_MS_HI;
		endcase
	endfunction : atfr_delay_ms

	// Codes 0000, 0001 and 101x are not accepted
	function automatic logic atfr_bknd_ok(input logic [31:0] v);
		atfr_bknd_ok = (v[31:4] == 28'h0) && (v[3:0] >= 4'h2) && (v[3:1] != 3'h5);
	endfunction : atfr_bknd_ok
endpackage : atfr_pkg

/* File: hw/atfr_skid.sv */
// Two-entry skid buffer for the routed channel words
`timescale 1ns/1ps
`default_nettype none
module atfr_skid #(
	parameter int unsigned W = 96
) (
	input  wire logic         core_clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic         s_valid_i,
	output logic              s_ready_o,
	input  wire logic [W-1:0] s_data_i,
	output logic              m_valid_o,
	input  wire logic         m_ready_i,
	output logic [W-1:0]      m_data_o
);
	logic [W-1:0] skid_reg;
	logic         skid_valid_reg;

	wire push = s_valid_i && s_ready_o;
	wire pop  = m_valid_o && m_ready_i;

	// Ready is a flop so the upstream path stays short
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			m_valid_o      <= 1'b0;
			skid_valid_reg <= 1'b0;
			s_ready_o      <= 1'b1;
			m_data_o       <= '0;
			skid_reg       <= '0;
		end else if (ce_i) begin
			if (push && m_valid_o && !m_ready_i) begin
				skid_reg       <= s_data_i;
				skid_valid_reg <= 1'b1;
				s_ready_o      <= 1'b0;
			end else if (push) begin
				m_data_o  <= s_data_i;
				m_valid_o <= 1'b1;
			end else if (pop && skid_valid_reg) begin
				m_data_o       <= skid_reg;
				skid_valid_reg <= 1'b0;
				s_ready_o      <= 1'b1;
			end else if (pop) begin
				m_valid_o <= 1'b0;
			end
		end
	end

	property p_skid_no_loss;
		@(posedge core_clk_i) disable iff (rst_i)
		ce_i && push && m_valid_o && !m_ready_i |=> skid_valid_reg && !s_ready_o;
	endproperty
	a_skid_no_loss: assert property (p_skid_no_loss) else $error("skid word dropped");
	c_skid_full: cover property (@(posedge core_clk_i) disable iff (rst_i) skid_valid_reg && m_valid_o);
endmodule : atfr_skid
`default_nettype wire

/* File: verification/atfr_sink_model.sv */
// Downstream consumer of the routed channel words, able to stall
`timescale 1ns/1ps
`default_nettype none
module atfr_sink_model (
	input  wire logic        core_clk_i,
	input  wire logic        stall_i,
	input  wire logic        ch_valid_i,
	input  wire logic [95:0] ch_data_i,
	output logic             ch_ready_o,
	output logic [95:0]      word_o,
	output logic [7:0]       cnt_o
);
	initial begin
		ch_ready_o = 1'b0;
		word_o     = '0;
		cnt_o      = 8'h00;
	end
	// Ready moves only off the sampling edge
	always @(negedge core_clk_i) begin
		ch_ready_o <= !stall_i;
	end
	// Count lets the bench see back-to-back words one by one
	always @(posedge core_clk_i) begin
		if (ch_valid_i && ch_ready_o) begin
			word_o <= ch_data_i;
			cnt_o  <= cnt_o + 8'h01;
		end
	end
endmodule : atfr_sink_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the trim, fault and routing register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	import atfr_pkg::*;
	localparam int unsigned CYC = 2;
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	logic        ce         = 1'b1;
	logic        reg_wr_i   = 1'b0;
	logic        reg_rd_i   = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic [31:0] reg_rdata_o;
	logic        reg_rvalid_o;
	logic        trim_factory_o;
	logic        trim_done_o;
	logic        backend_fault_register_i = 1'b0;
	logic        pwr_stage_rst_o;
	logic [3:0]  pwm_ch_i   = 4'h0;
	logic [3:0]  pwm_pin_o;
	logic [2:0]  mod_three_level_o;
	logic        in_valid_i = 1'b0;
	logic        in_ready_o;
	logic [23:0] left_s     = 24'h0;
	logic [23:0] right_s    = 24'h0;
	logic [23:0] eq_s       = 24'h0;
	logic        ch_valid_o;
	logic        ch_ready;
	logic [95:0] ch_data_o;
	logic        stall      = 1'b0;
	logic [95:0] word;
	logic [7:0]  cnt;
	int          n_fail     = 0;
	int          tests_run  = 0;
	int          cyc        = 0;

	always #5 core_clk_i = ~core_clk_i;

	atfr_regs #(.CYC_MS(CYC)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .trim_factory_o(trim_factory_o),
		.trim_done_o(trim_done_o), .backend_fault_register_i(backend_fault_register_i), .pwr_stage_rst_o(pwr_stage_rst_o),
		.pwm_ch_i(pwm_ch_i), .pwm_pin_o(pwm_pin_o), .mod_three_level_o(mod_three_level_o),
		.in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .serial_input_left_i(left_s),
		.serial_input_right_i(right_s), .after_equalizer_biquads_i(eq_s), .ch_valid_o(ch_valid_o),
		.ch_ready_i(ch_ready), .ch_data_o(ch_data_o));

	atfr_sink_model i_sink (.core_clk_i(core_clk_i), .stall_i(stall), .ch_valid_i(ch_valid_o),
		.ch_data_i(ch_data_o), .ch_ready_o(ch_ready), .word_o(word), .cnt_o(cnt));

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results

	// Hang guard, well above the expected run length
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	task automatic reset_dut();
		@(negedge core_clk_i);
		rst_i = 1'b1;
		repeat (10) @(negedge core_clk_i);
		rst_i = 1'b0;
	endtask : reset_dut

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge core_clk_i);
		reg_addr_i  = a;
		reg_wdata_i = d;
		reg_wr_i    = 1'b1;
		@(negedge core_clk_i);
		reg_wr_i    = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(negedge core_clk_i);
		reg_addr_i = a;
		reg_rd_i   = 1'b1;
		@(negedge core_clk_i);
		reg_rd_i   = 1'b0;
		`CHK("rvalid", 1'b1, reg_rvalid_o)
		`CHK(nm, e, reg_rdata_o)
	endtask : rd

	task automatic send(input logic [23:0] l, input logic [23:0] r, input logic [23:0] e);
		@(negedge core_clk_i);
		left_s     = l;
		right_s    = r;
		eq_s       = e;
		in_valid_i = 1'b1;
		for (int k = 0; k < 50 && in_ready_o !== 1'b1; k++) @(negedge core_clk_i);
		@(negedge core_clk_i);
		in_valid_i = 1'b0;
	endtask : send

	task automatic getw(input logic [95:0] e);
		logic [7:0] prev;
		prev = cnt;
		for (int k = 0; k < 50 && cnt === prev; k++) @(negedge core_clk_i);
		`CHK("word", e, word)
	endtask : getw

	function automatic logic [23:0] pick(input logic [2:0] c, input logic [23:0] l, input logic [23:0] r);
		return (c == 3'h0) ? l : (c == 3'h1) ? r : 24'h0;
	endfunction : pick

	// Expected word from the routing value, fourth-channel select and the samples
	function automatic logic [95:0] expw(input logic [31:0] m, input logic d8, input logic [23:0] l,
		input logic [23:0] r, input logic [23:0] e);
		logic [23:0] s1;
		logic [23:0] s2;
		logic [24:0] sum;
		s1  = pick(m[22:20], l, r);
		s2  = pick(m[18:16], l, r);
		sum = {l[23], l} + {r[23], r};
		return {d8 ? e : sum[24:1], m[26] ? -s1 : s1, m[25] ? -s2 : s2, m[24] ? -s1 : s1};
	endfunction : expw

	logic [31:0] cfg [4] = '{32'h0090_0008, 32'h076e_0000, 32'h0589_0008, 32'h0200_0000};

	initial begin
		logic [31:0] m;
		logic [23:0] r;
		int n;
		reset_dut();
		rd(ADDR_TRIM, 32'h02, "trim");
		rd(ADDR_BKND, 32'h02, "bknd");
		rd(ADDR_INMUX, 32'h0001_7772, "inmux");
		rd(ADDR_CH4, 32'h0000_4303, "ch4");
		rd(ADDR_XBAR, 32'h0102_1300, "xbar");
		rd(8'h30, 32'h0, "unmapped");
		for (int i = 0; i < 4; i++) begin
			pwm_ch_i = 4'h1 << i;
			@(negedge core_clk_i);
			`CHK("pins", {i == 3, i == 1, i == 2, i == 0}, pwm_pin_o)
		end
		$display("test reset_defaults done");
		wr(ADDR_TRIM, 32'h0);
		@(negedge core_clk_i);
		`CHK("factory", 1'b1, trim_factory_o)
		rd(ADDR_TRIM, 32'h02, "trim_busy");
		for (int k = 0; k < 40 && trim_done_o !== 1'b1; k++) @(negedge core_clk_i);
		`CHK("done", 1'b1, trim_done_o)
		rd(ADDR_TRIM, 32'h00, "trim_fin");
		wr(ADDR_TRIM, 32'h02);
		rd(ADDR_TRIM, 32'h42, "trim_flag");
		`CHK("factory", 1'b0, trim_factory_o)
		$display("test trim done");
		for (int i = 0; i < 4; i++) begin
			m = (RST_INMUX & ~MSK_INMUX) | cfg[i];
			wr(ADDR_INMUX, m);
			wr(ADDR_CH4, (RST_CH4 & ~MSK_CH4) | {23'h0, i[0], 8'h00});
			rd(ADDR_INMUX, m, "inmux");
			// Negative right sample checks the signed average, equal samples the plain one
			r = (i == 0) ? 24'hf00000 : (i == 2) ? 24'h100002 : 24'h200000;
			send(24'h100000 + 24'(i), r, 24'h345678);
			getw(expw(m, i[0], 24'h100000 + 24'(i), r, 24'h345678));
			`CHK("mod", {m[3], m[19], m[23]}, mod_three_level_o)
		end
		$display("test routing done");
		for (int k = 0; k < 4; k++) begin
			m = RST_XBAR & ~MSK_XBAR;
			m[21:20] = 2'(k);
			m[17:16] = 2'(k);
			m[13:12] = 2'(k);
			m[9:8]   = 2'(k);
			wr(ADDR_XBAR, m);
			rd(ADDR_XBAR, m, "xbar");
			pwm_ch_i = 4'h1 << k;
			@(negedge core_clk_i);
			`CHK("pins", 4'hf, pwm_pin_o)
			pwm_ch_i = ~(4'h1 << k);
			@(negedge core_clk_i);
			`CHK("pins", 4'h0, pwm_pin_o)
		end
		// Clock enable low must freeze the crossbar setting
		ce = 1'b0;
		wr(ADDR_XBAR, RST_XBAR);
		ce = 1'b1;
		rd(ADDR_XBAR, m, "xbar_frozen");
		$display("test crossbar done");
		// Receiver stalls: two words must be held, the third refused
		wr(ADDR_INMUX, RST_INMUX);
		stall = 1'b1;
		send(24'h000011, 24'h000022, 24'h000033);
		send(24'h000044, 24'h000055, 24'h000066);
		repeat (2) @(negedge core_clk_i);
		`CHK("in_ready", 1'b0, in_ready_o)
		stall = 1'b0;
		getw(expw(RST_INMUX, 1'b1, 24'h000011, 24'h000022, 24'h000033));
		getw(expw(RST_INMUX, 1'b1, 24'h000044, 24'h000055, 24'h000066));
		$display("test buffer done");
		wr(ADDR_BKND, 32'h0a);
		rd(ADDR_BKND, 32'h02, "bknd_rsvd");
		wr(ADDR_BKND, 32'h03);
		rd(ADDR_BKND, 32'h03, "bknd_set");
		wr(ADDR_BKND, 32'h04);
		rd(ADDR_BKND, 32'h03, "bknd_lock");
		pwm_ch_i = 4'hf;
		@(negedge core_clk_i);
		backend_fault_register_i = 1'b1;
		@(negedge core_clk_i);
		backend_fault_register_i = 1'b0;
		`CHK("pstage_rst", 1'b1, pwr_stage_rst_o)
		`CHK("pins_halt", 4'h0, pwm_pin_o)
		n = 1;
		for (int k = 0; k < 3000 && pwr_stage_rst_o === 1'b1; k++) begin
			@(negedge core_clk_i);
			if (pwr_stage_rst_o === 1'b1) n++;
		end
		`CHK("wait", 449 * CYC, n)
		@(negedge core_clk_i);
		`CHK("pins_run", 4'hf, pwm_pin_o)
		reset_dut();
		rd(ADDR_BKND, 32'h02, "bknd_rst");
		wr(ADDR_TRIM, 32'h0);
		for (int k = 0; k < 40 && trim_done_o !== 1'b1; k++) @(negedge core_clk_i);
		rd(ADDR_TRIM, 32'h00, "trim_again");
		wr(ADDR_BKND, 32'h09);
		rd(ADDR_BKND, 32'h09, "bknd_new");
		$display("test fault done");
		results();
	end
endmodule : testbench
`default_nettype wire
